// >>> tpi_pkg.sv
package tpi_pkg;

    // register indices; byte address is four times the index
    localparam int         TPI_IDX_W          = 10;
    localparam int         TPI_ADDR_W         = 12;
    localparam logic [9:0] TPI_IDX_V_ALT      = 10'h302;
    localparam logic [9:0] TPI_IDX_W_ALT      = 10'h304;
    localparam logic [9:0] TPI_IDX_U_ALT      = 10'h306;
    localparam logic [9:0] TPI_IDX_BUF_FIRST  = 10'h30a;
    localparam logic [9:0] TPI_IDX_BUF_SECOND = 10'h30b;
    localparam logic [9:0] TPI_IDX_IRQ_IVAL   = 10'h30d;
    localparam logic [9:0] TPI_IDX_V_WIDTH    = 10'h348;
    localparam logic [9:0] TPI_IDX_W_WIDTH    = 10'h34a;
    localparam logic [9:0] TPI_IDX_U_WIDTH    = 10'h34e;
    localparam logic [9:0] TPI_IDX_SPECIAL    = 10'h35e;
    localparam logic [9:0] TPI_IDX_CONTROL    = 10'h310;
    localparam logic [9:0] TPI_IDX_STATUS     = 10'h312;
    localparam logic [9:0] TPI_IDX_PERIOD     = 10'h350;
    localparam logic [9:0] TPI_IDX_DEAD_TIME  = 10'h352;

    // control register fields
    localparam int TPI_CTL_MODE_LOW   = 0;
    localparam int TPI_CTL_MODE_HIGH  = 1;
    localparam int TPI_CTL_FUNC_EN    = 2;
    localparam int TPI_CTL_OUT_EN     = 3;
    localparam int TPI_CTL_PROTECT    = 4;
    localparam int TPI_CTL_DETECTED   = 5;
    localparam int TPI_CTL_SAWTOOTH   = 6;
    localparam int TPI_CTL_ACT_HIGH   = 7;
    localparam int TPI_CTL_MODE1      = 8;
    localparam int TPI_CTL_DT_CLK     = 9;
    localparam int TPI_CTL_DT_DISABLE = 10;
    localparam int TPI_CTL_RUN        = 11;
    localparam int TPI_CTL_W          = 12;
    localparam logic [11:0] TPI_CTL_RESET = 12'h000;

    // output buffers: all arms off after reset
    localparam logic [5:0]  TPI_BUF_RESET  = 6'h3f;
    localparam logic [3:0]  TPI_IVAL_RESET = 4'h1;
    localparam logic [1:0]  TPI_RESP_OKAY   = 2'h0;
    localparam logic [1:0]  TPI_RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic        awvalid;
        logic [11:0] awaddr;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [11:0] araddr;
        logic        rready;
    } tpi_axi_req_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } tpi_axi_rsp_t;

endpackage

// >>> tpi_pwm.sv
// Notes on behaviour
// - carrier sets period, phase timers set widths
// - phase output active level selectable high/low
// - carrier reloads periodically, phases are one-shots
// - reload sync: every underflow or odd ones
// - mode high zero: request every n-th underflow
// - mode 10b: first at 2n-1, then 2n
// - mode 11b: first at 2n-2, then 2n
// - interval counter write-only, values 1 to 15
// - phase counts n clocks, stops, level changes
// - zero width: no start, no phase interrupt
// - dead time delays entry into active level
// - mode 1 alternates alternate and primary width
// - six buffer bits, zero active one inactive
// - buffer reads return output shift registers
// - first buffer initial level, second next level
// - both arms active: detect, disable, high-z
// - low nmi pin disables outputs, raises nmi
// - dead time counts base or half clock
// - triangular two underflows, sawtooth one per cycle
`timescale 1ns/100ps
module tpi_pwm
    import tpi_pkg::*;
#(
    parameter int CNT_W = 16,
    parameter int DT_W  = 8
) (
    input  wire logic         mclk,
    input  wire logic         reset,
    input  wire tpi_axi_req_t axi_req,
    output tpi_axi_rsp_t      axi_rsp,
    input  wire logic         nmi_n,
    output logic [5:0]        gate_level,
    output logic [5:0]        gate_oe,
    output logic              carrier_irq,
    output logic [2:0]        phase_irq,
    output logic              nmi_irq
);

    if (CNT_W < 8 || CNT_W > 16 || DT_W < 1 || DT_W > 8) begin : g_bad_width
        $error("tpi_pwm: unsupported counter widths");
    end

    typedef struct packed {
        tpi_axi_rsp_t                axi;
        logic                        aw_held;
        logic [TPI_IDX_W-1:0]        aw_idx;
        logic                        w_held;
        logic [31:0]                 w_data;
        logic [3:0]                  w_strb;
        logic [TPI_CTL_W-1:0]        ctl;
        logic                        reload_sync;
        logic [3:0]                  ival;
        logic [4:0]                  ival_cnt;
        logic [CNT_W-1:0]            period;
        logic [CNT_W-1:0]            period_act;
        logic [CNT_W-1:0]            carrier_cnt;
        logic                        reload_ctl;
        logic [DT_W-1:0]             dead_time;
        logic                        dt_half;
        logic [2:0][CNT_W-1:0]       width;
        logic [2:0][CNT_W-1:0]       alt_width;
        logic [2:0][CNT_W-1:0]       phase_cnt;
        logic [2:0]                  phase_busy;
        logic [2:0]                  use_alt;
        logic [5:0]                  buf_first;
        logic [5:0]                  buf_second;
        logic                        buf_pending;
        logic [5:0]                  shift_cur;
        logic [5:0]                  shift_nxt;
        logic [5:0][DT_W-1:0]        dt_cnt;
        logic [2:0]                  nmi_sync;
        logic [5:0]                  gate;
        logic [5:0]                  oe;
        logic                        carrier_irq;
        logic [2:0]                  phase_irq;
        logic                        nmi_irq;
    } tpi_state_t;

    tpi_state_t q_reg;
    tpi_state_t q_next;

    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] d,
                                            input logic [3:0]  s);
        logic [15:0] r;
        r = old;
        if (s[0]) begin
            r[7:0] = d[7:0];
        end
        if (s[1]) begin
            r[15:8] = d[15:8];
        end
        return r;
    endfunction

    function automatic logic is_mapped(input logic [TPI_IDX_W-1:0] i);
        return i == TPI_IDX_V_ALT || i == TPI_IDX_W_ALT ||
               i == TPI_IDX_U_ALT || i == TPI_IDX_BUF_FIRST ||
               i == TPI_IDX_BUF_SECOND || i == TPI_IDX_IRQ_IVAL ||
               i == TPI_IDX_V_WIDTH || i == TPI_IDX_W_WIDTH ||
               i == TPI_IDX_U_WIDTH || i == TPI_IDX_SPECIAL ||
               i == TPI_IDX_CONTROL || i == TPI_IDX_STATUS ||
               i == TPI_IDX_PERIOD || i == TPI_IDX_DEAD_TIME;
    endfunction

    // both arms of any phase at zero means both switches on
    function automatic logic shoot_through(input logic [5:0] b);
        return (b[1:0] == 2'b00) || (b[3:2] == 2'b00) ||
               (b[5:4] == 2'b00);
    endfunction

    always_comb begin
        logic                 run;
        logic                 underflow;
        logic                 rising;
        logic                 do_write;
        logic [TPI_IDX_W-1:0] ridx;
        logic [TPI_IDX_W-1:0] widx;
        logic [31:0]          wd;
        logic [3:0]           ws;
        logic [CNT_W-1:0]     sel;
        logic                 count_it;
        logic [4:0]           inc;
        logic                 dt_tick;
        logic [5:0]           want_old;
        logic [5:0]           want_new;
        logic                 nmi_low;
        logic [31:0]          rd;
        logic [15:0]          tmp;
        q_next    = q_reg;
        run       = 1'b0;
        underflow = 1'b0;
        rising    = 1'b0;
        do_write  = 1'b0;
        ridx      = axi_req.araddr[TPI_ADDR_W-1:2];
        widx      = q_reg.aw_idx;
        wd        = q_reg.w_data;
        ws        = q_reg.w_strb;
        sel       = '0;
        count_it  = 1'b0;
        inc       = '0;
        dt_tick   = 1'b0;
        want_old  = ~q_reg.shift_cur;
        want_new  = '0;
        nmi_low   = ~q_reg.nmi_sync[1];
        rd        = '0;
        tmp       = '0;

        q_next.carrier_irq = 1'b0;
        q_next.phase_irq   = 3'h0;

        // pin synchroniser; the second stage feeds logic, the third only the nmi edge detect
        q_next.nmi_sync = {q_reg.nmi_sync[1], q_reg.nmi_sync[0], nmi_n};
        q_next.nmi_irq  = q_reg.nmi_sync[2] & ~q_reg.nmi_sync[1];

        // bus write channels: address and data taken in either order
        if (axi_req.awvalid && q_reg.axi.awready) begin
            q_next.aw_held = 1'b1;
            q_next.aw_idx  = axi_req.awaddr[TPI_ADDR_W-1:2];
        end
        if (axi_req.wvalid && q_reg.axi.wready) begin
            q_next.w_held = 1'b1;
            q_next.w_data = axi_req.wdata;
            q_next.w_strb = axi_req.wstrb;
        end
        if (q_reg.axi.bvalid && axi_req.bready) begin
            q_next.axi.bvalid = 1'b0;
        end
        if (q_reg.aw_held && q_reg.w_held && !q_reg.axi.bvalid) begin
            do_write          = 1'b1;
            q_next.aw_held    = 1'b0;
            q_next.w_held     = 1'b0;
            q_next.axi.bvalid = 1'b1;
            q_next.axi.bresp  = is_mapped(widx) ? TPI_RESP_OKAY
                                                : TPI_RESP_SLVERR;
        end

        // carrier timer
        run = q_reg.ctl[TPI_CTL_FUNC_EN] & q_reg.ctl[TPI_CTL_RUN];
        if (!run) begin
            q_next.carrier_cnt = q_reg.period;
            q_next.period_act  = q_reg.period;
            q_next.reload_ctl  = 1'b0;
            q_next.use_alt     = 3'h7;
            q_next.ival_cnt    = {4'h0, q_reg.ctl[TPI_CTL_MODE_HIGH] &
                                        q_reg.ctl[TPI_CTL_MODE_LOW]};
        end else if (q_reg.carrier_cnt == '0) begin
            underflow         = 1'b1;
            // reload control toggles each underflow: odd ones are rising
            q_next.reload_ctl = ~q_reg.reload_ctl;
            rising            = ~q_reg.reload_ctl;
            if (!q_reg.reload_sync || rising) begin
                q_next.period_act  = q_reg.period;
                q_next.carrier_cnt = q_reg.period;
            end else begin
                q_next.carrier_cnt = q_reg.period_act;
            end
        end else begin
            q_next.carrier_cnt = q_reg.carrier_cnt - 1'b1;
        end

        // interrupt thinning
        if (underflow) begin
            if (!q_reg.ctl[TPI_CTL_MODE_HIGH]) begin
                count_it = 1'b1;
            end else if (!q_reg.ctl[TPI_CTL_MODE_LOW]) begin
                count_it = rising;
            end else begin
                count_it = ~rising;
            end
        end
        if (count_it) begin
            inc = q_reg.ival_cnt + 5'h01;
            if (inc >= {1'b0, q_reg.ival}) begin
                q_next.carrier_irq = 1'b1;
                q_next.ival_cnt    = '0;
            end else begin
                q_next.ival_cnt = inc;
            end
        end

        // phase one-shots
        for (int p = 0; p < 3; p++) begin
            if (q_reg.phase_busy[p]) begin
                if (q_reg.phase_cnt[p] == {{(CNT_W-1){1'b0}}, 1'b1}) begin
                    // end of pulse: next level from the second buffer
                    q_next.phase_busy[p] = 1'b0;
                    q_next.phase_irq[p]  = 1'b1;
                    q_next.shift_cur[2*p +: 2] = q_reg.shift_nxt[2*p +: 2];
                end else begin
                    q_next.phase_cnt[p] = q_reg.phase_cnt[p] - 1'b1;
                end
            end
            if (underflow) begin
                if (q_reg.ctl[TPI_CTL_MODE1]) begin
                    sel = q_reg.use_alt[p] ? q_reg.alt_width[p]
                                           : q_reg.width[p];
                    q_next.use_alt[p] = ~q_reg.use_alt[p];
                end else begin
                    sel = q_reg.width[p];
                end
                // every phase whose selected width (alternate or primary in mode 1) is nonzero starts on the carrier underflow
                if (sel != '0) begin
                    q_next.phase_cnt[p]  = sel;
                    q_next.phase_busy[p] = 1'b1;
                end
            end
        end

        // transfer trigger; sawtooth reloads every carrier cycle
        if (underflow && (q_reg.buf_pending ||
                          q_reg.ctl[TPI_CTL_SAWTOOTH])) begin
            q_next.shift_cur   = q_reg.buf_first;
            q_next.shift_nxt   = q_reg.buf_second;
            q_next.buf_pending = 1'b0;
        end

        // register writes
        if (do_write) begin
            if (widx == TPI_IDX_V_ALT) begin
                q_next.alt_width[1] = CNT_W'(merge16(16'(q_reg.alt_width[1]),
                                                     wd, ws));
            end else if (widx == TPI_IDX_W_ALT) begin
                q_next.alt_width[2] = CNT_W'(merge16(16'(q_reg.alt_width[2]),
                                                     wd, ws));
            end else if (widx == TPI_IDX_U_ALT) begin
                q_next.alt_width[0] = CNT_W'(merge16(16'(q_reg.alt_width[0]),
                                                     wd, ws));
            end else if (widx == TPI_IDX_V_WIDTH) begin
                q_next.width[1] = CNT_W'(merge16(16'(q_reg.width[1]), wd, ws));
            end else if (widx == TPI_IDX_W_WIDTH) begin
                q_next.width[2] = CNT_W'(merge16(16'(q_reg.width[2]), wd, ws));
            end else if (widx == TPI_IDX_U_WIDTH) begin
                q_next.width[0] = CNT_W'(merge16(16'(q_reg.width[0]), wd, ws));
            end else if (widx == TPI_IDX_PERIOD) begin
                q_next.period = CNT_W'(merge16(16'(q_reg.period), wd, ws));
            end else if ((widx == TPI_IDX_BUF_FIRST ||
                          widx == TPI_IDX_BUF_SECOND) && ws[0]) begin
                if (widx == TPI_IDX_BUF_FIRST) begin
                    q_next.buf_first = wd[5:0];
                end else begin
                    q_next.buf_second = wd[5:0];
                end
                q_next.buf_pending = 1'b1;
            end else if (widx == TPI_IDX_IRQ_IVAL && ws[0]) begin
                // zero is outside the legal range and is ignored
                if (wd[3:0] != 4'h0) begin
                    q_next.ival     = wd[3:0];
                    q_next.ival_cnt = '0;
                end
            end else if (widx == TPI_IDX_SPECIAL && ws[0]) begin
                q_next.reload_sync = wd[0];
            end else if (widx == TPI_IDX_DEAD_TIME && ws[0]) begin
                q_next.dead_time = wd[DT_W-1:0];
            end else if (widx == TPI_IDX_CONTROL) begin
                tmp = merge16({4'h0, q_reg.ctl}, wd, ws);
                q_next.ctl = tmp[TPI_CTL_W-1:0];
                // detect flag is only cleared by software, never set
                q_next.ctl[TPI_CTL_DETECTED] = q_reg.ctl[TPI_CTL_DETECTED] &
                                               tmp[TPI_CTL_DETECTED];
            end
        end

        // protection: hardware disable wins over a software enable
        if (q_next.ctl[TPI_CTL_PROTECT] &&
            (shoot_through(q_next.buf_first) ||
             shoot_through(q_next.buf_second))) begin
            q_next.ctl[TPI_CTL_DETECTED] = 1'b1;
            q_next.ctl[TPI_CTL_OUT_EN]   = 1'b0;
        end
        if (nmi_low) begin
            q_next.ctl[TPI_CTL_OUT_EN] = 1'b0;
        end

        // dead time: half-rate tick alternates on a divider bit
        q_next.dt_half = ~q_reg.dt_half;
        dt_tick = ~q_reg.ctl[TPI_CTL_DT_CLK] | q_reg.dt_half;
        want_new = ~q_next.shift_cur;
        for (int b = 0; b < 6; b++) begin
            if (want_new[b] && !want_old[b]) begin
                q_next.dt_cnt[b] = q_reg.dead_time;
            end else if (!want_new[b]) begin
                q_next.dt_cnt[b] = '0;
            end else if (dt_tick && q_reg.dt_cnt[b] != '0) begin
                q_next.dt_cnt[b] = q_reg.dt_cnt[b] - 1'b1;
            end
            // active once the dead-time counter has run out, or at once when dead time is disabled
            q_next.gate[b] = (want_old[b] &&
                              (q_reg.ctl[TPI_CTL_DT_DISABLE] ||
                               q_reg.dt_cnt[b] == '0)) ==
                             q_reg.ctl[TPI_CTL_ACT_HIGH];
        end
        q_next.oe = {6{q_reg.ctl[TPI_CTL_FUNC_EN] &
                       q_reg.ctl[TPI_CTL_OUT_EN] & ~nmi_low}};

        // read channel
        if (q_reg.axi.rvalid && axi_req.rready) begin
            q_next.axi.rvalid = 1'b0;
        end
        if (axi_req.arvalid && q_reg.axi.arready) begin
            if (ridx == TPI_IDX_BUF_FIRST) begin
                rd = {26'h0, q_reg.shift_cur};
            end else if (ridx == TPI_IDX_BUF_SECOND) begin
                rd = {26'h0, q_reg.shift_nxt};
            end else if (ridx == TPI_IDX_SPECIAL) begin
                rd = {31'h0, q_reg.reload_sync};
            end else if (ridx == TPI_IDX_CONTROL) begin
                rd = {20'h0, q_reg.ctl};
            end else if (ridx == TPI_IDX_STATUS) begin
                rd = {26'h0, nmi_low, q_reg.phase_busy,
                      q_reg.reload_ctl, run};
            end else if (ridx == TPI_IDX_PERIOD) begin
                rd = 32'(q_reg.period);
            end else if (ridx == TPI_IDX_DEAD_TIME) begin
                rd = 32'(q_reg.dead_time);
            end
            q_next.axi.rvalid = 1'b1;
            q_next.axi.rdata  = rd;
            q_next.axi.rresp  = is_mapped(ridx) ? TPI_RESP_OKAY
                                                : TPI_RESP_SLVERR;
        end
        q_next.axi.awready = ~q_next.aw_held;
        q_next.axi.wready  = ~q_next.w_held;
        q_next.axi.arready = ~q_next.axi.rvalid;
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            q_reg             <= '0;
            q_reg.axi.awready <= 1'b1;
            q_reg.axi.wready  <= 1'b1;
            q_reg.axi.arready <= 1'b1;
            q_reg.ctl         <= TPI_CTL_RESET;
            q_reg.ival        <= TPI_IVAL_RESET;
            q_reg.use_alt     <= 3'h7;
            q_reg.buf_first   <= TPI_BUF_RESET;
            q_reg.buf_second  <= TPI_BUF_RESET;
            q_reg.shift_cur   <= TPI_BUF_RESET;
            q_reg.shift_nxt   <= TPI_BUF_RESET;
            q_reg.nmi_sync    <= 3'h7;
        end else begin
            q_reg <= q_next;
        end
    end

    assign axi_rsp     = q_reg.axi;
    assign gate_level  = q_reg.gate;
    assign gate_oe     = q_reg.oe;
    assign carrier_irq = q_reg.carrier_irq;
    assign phase_irq   = q_reg.phase_irq;
    assign nmi_irq     = q_reg.nmi_irq;

endmodule

// >>> tpi_pwm_sva.sv
`timescale 1ns/100ps
module tpi_pwm_sva
    import tpi_pkg::*;
(
    input wire logic         mclk,
    input wire logic         reset,
    input wire tpi_axi_req_t axi_req,
    input wire tpi_axi_rsp_t axi_rsp,
    input wire logic         nmi_n,
    input wire logic [5:0]   gate_level,
    input wire logic [5:0]   gate_oe,
    input wire logic         carrier_irq,
    input wire logic [2:0]   phase_irq,
    input wire logic         nmi_irq
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    sequence s_wr_take;
        axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready;
    endsequence
    sequence s_rd_take;
        axi_req.arvalid && axi_rsp.arready;
    endsequence

    // address and data are held one edge, the write lands on the next
    chk_wr_answer: assert property (s_wr_take |=> ##1 axi_rsp.bvalid)
        else $error("write answer late");
    chk_rd_answer: assert property (s_rd_take |=> axi_rsp.rvalid)
        else $error("read answer late");
    chk_rd_hold: assert property (axi_rsp.rvalid && !axi_req.rready
        |=> axi_rsp.rvalid && $stable(axi_rsp.rdata))
        else $error("read data not held");
    chk_unmapped_err: assert property (s_rd_take
        ##0 (axi_req.araddr == 12'hffc) |=> axi_rsp.rresp == TPI_RESP_SLVERR)
        else $error("unmapped read not refused");
    // enables move as one group, so a half-released bridge never occurs
    chk_oe_group: assert property (gate_oe == 6'h00 || gate_oe == 6'h3f)
        else $error("output enables split");
    chk_nmi_cut: assert property (!nmi_n [*6] |-> gate_oe == 6'h00)
        else $error("outputs not cut on nmi");
    chk_nmi_pulse: assert property (nmi_irq |=> !nmi_irq)
        else $error("nmi request longer than one cycle");
    chk_phase_pulse: assert property (phase_irq[0] |=> !phase_irq[0])
        else $error("phase request longer than one cycle");
endmodule

// >>> tpi_bridge.sv
`timescale 1ns/100ps
module tpi_bridge (
    input wire logic       mclk,
    input wire logic       act_high,
    input wire logic [5:0] gate_level,
    input wire logic [5:0] gate_oe,
    output int             shoot_cnt
);
    logic [5:0] arm_on;
    // a released gate is pulled off on the driver board
    assign arm_on = gate_oe & (act_high ? gate_level : ~gate_level);
    initial shoot_cnt = 0;
    always @(posedge mclk)
        for (int p = 0; p < 3; p++)
            if (arm_on[2*p] && arm_on[2*p+1]) shoot_cnt <= shoot_cnt + 1;
endmodule

// >>> tpi_pwm_test.sv
`timescale 1ns/100ps
bind tpi_pwm tpi_pwm_sva i_sva (.mclk(mclk), .reset(reset),
    .axi_req(axi_req), .axi_rsp(axi_rsp), .nmi_n(nmi_n),
    .gate_level(gate_level), .gate_oe(gate_oe), .carrier_irq(carrier_irq),
    .phase_irq(phase_irq), .nmi_irq(nmi_irq));
module tpi_pwm_test;
    import tpi_pkg::*;
    localparam logic [31:0] RUN = 32'h1 << TPI_CTL_RUN;
    localparam logic [31:0] ACT = 32'h1 << TPI_CTL_ACT_HIGH;
    localparam logic [31:0] DTD = 32'h1 << TPI_CTL_DT_DISABLE;
    localparam logic [31:0] STP = 32'h1 << TPI_CTL_FUNC_EN
        | 32'h1 << TPI_CTL_OUT_EN | 32'h1 << TPI_CTL_DT_DISABLE;
    logic         mclk, reset, nmi_n, carrier_irq, nmi_irq, act_high;
    tpi_axi_req_t axi_req;
    tpi_axi_rsp_t axi_rsp;
    logic [5:0]   gate_level, gate_oe;
    logic [2:0]   phase_irq;
    logic [31:0]  lfsr, rd_data;
    logic [1:0]   resp;
    int           err_total, cmp_count, shoot_cnt, t0, t1, t2, k, n;

    tpi_pwm i_dut (.mclk(mclk), .reset(reset), .axi_req(axi_req),
        .axi_rsp(axi_rsp), .nmi_n(nmi_n), .gate_level(gate_level),
        .gate_oe(gate_oe), .carrier_irq(carrier_irq),
        .phase_irq(phase_irq), .nmi_irq(nmi_irq));
    tpi_bridge i_bridge (.mclk(mclk), .act_high(act_high),
        .gate_level(gate_level), .gate_oe(gate_oe), .shoot_cnt(shoot_cnt));

    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    function automatic logic [31:0] lfsr_next(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [9:0] idx, input logic [31:0] d);
        axi_req.awaddr <= {idx, 2'b00};
        axi_req.wdata <= d;
        axi_req.wstrb <= 4'hf;
        axi_req.awvalid <= 1'b1;
        axi_req.wvalid <= 1'b1;
        axi_req.bready <= 1'b1;
        do begin
            @(posedge mclk);
            if (axi_rsp.awready && axi_req.awvalid) axi_req.awvalid <= 1'b0;
            if (axi_rsp.wready && axi_req.wvalid) axi_req.wvalid <= 1'b0;
        end while (!axi_rsp.bvalid);
        // bready stays up, so the answer is taken on the next edge and a following call never sees it
        resp = axi_rsp.bresp;
    endtask

    task automatic rd(input logic [9:0] idx);
        axi_req.araddr <= {idx, 2'b00};
        axi_req.arvalid <= 1'b1;
        axi_req.rready <= 1'b1;
        do begin
            @(posedge mclk);
            if (axi_rsp.arready) axi_req.arvalid <= 1'b0;
        end while (!axi_rsp.rvalid);
        rd_data = axi_rsp.rdata;
        resp = axi_rsp.rresp;
    endtask

    task automatic wait_car;
        do @(posedge mclk); while (!carrier_irq);
    endtask

    // nine edges only, so the next carrier request is not swallowed
    task automatic ph;
        t0 = -1;
        t1 = -1;
        t2 = -1;
        wait_car;
        for (int i = 0; i < 9; i++) begin
            @(posedge mclk);
            if (phase_irq[0] && t0 < 0) t0 = i;
            if (phase_irq[1] && t1 < 0) t1 = i;
            if (phase_irq[2] && t2 < 0) t2 = i;
        end
    endtask

    task automatic end_sim;
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial begin
        #(20000 * 100);
        err_total++;
        end_sim;
    end

    initial begin
        axi_req = '0;
        nmi_n = 1'b1;
        act_high = 1'b0;
        reset = 1'b1;
        err_total = 0;
        cmp_count = 0;
        lfsr = 32'h54f0b24f;
        repeat (8) @(posedge mclk);
        reset <= 1'b0;
        repeat (3) @(posedge mclk);
        cmp(gate_level, 6'h3f);
        rd(TPI_IDX_BUF_FIRST);
        cmp(rd_data, 32'h3f);
        rd(TPI_IDX_U_WIDTH);
        cmp(rd_data, 32'h0);
        rd(10'h3ff);
        cmp(resp, TPI_RESP_SLVERR);
        wr(10'h3ff, 32'h0);
        cmp(resp, TPI_RESP_SLVERR);
        $display("register test done");
        wr(TPI_IDX_PERIOD, 32'd9);
        wr(TPI_IDX_U_WIDTH, 32'd2);
        wr(TPI_IDX_V_WIDTH, 32'd5);
        wr(TPI_IDX_W_WIDTH, 32'd0);
        // interval is only rewritten with the carrier stopped
        for (int j = 0; j < 3; j++) begin
            lfsr = lfsr_next(lfsr);
            n = lfsr % 15 + 1;
            wr(TPI_IDX_CONTROL, STP);
            wr(TPI_IDX_IRQ_IVAL, n);
            wr(TPI_IDX_CONTROL, STP | RUN);
            wait_car;
            k = 0;
            do begin
                @(posedge mclk);
                k++;
            end while (!carrier_irq);
            cmp(k, n * 10);
        end
        $display("interval test done");
        wr(TPI_IDX_CONTROL, STP);
        wr(TPI_IDX_IRQ_IVAL, 32'd1);
        wr(TPI_IDX_U_ALT, 32'd2);
        wr(TPI_IDX_V_ALT, 32'd4);
        wr(TPI_IDX_CONTROL, STP | RUN);
        ph;
        cmp(t1 - t0, 3);
        cmp(t2, -1);
        wr(TPI_IDX_CONTROL, STP);
        wr(TPI_IDX_CONTROL, STP | RUN | 32'h1 << TPI_CTL_MODE1);
        ph;
        k = t1 - t0;
        ph;
        cmp(k, 2);
        cmp(t1 - t0, 3);
        cmp(shoot_cnt, 0);
        $display("phase test done");
        wr(TPI_IDX_CONTROL, STP & ~(32'h1 << TPI_CTL_OUT_EN));
        act_high <= 1'b1;
        wr(TPI_IDX_CONTROL, STP | RUN | ACT | 32'h1 << TPI_CTL_PROTECT);
        repeat (3) @(posedge mclk);
        cmp(gate_level, 6'h00);
        wr(TPI_IDX_BUF_FIRST, 32'h3c);
        repeat (12) @(posedge mclk);
        rd(TPI_IDX_CONTROL);
        cmp(rd_data[TPI_CTL_DETECTED], 1'b1);
        cmp(gate_oe, 6'h00);
        wr(TPI_IDX_BUF_FIRST, 32'h3f);
        // the safe pattern must reach the shift register before enabling
        wait_car;
        wr(TPI_IDX_CONTROL, STP | RUN | ACT);
        repeat (3) @(posedge mclk);
        cmp(gate_oe, 6'h3f);
        // one dead-time tick holds the upper U arm off one more cycle
        wr(TPI_IDX_DEAD_TIME, 32'd1);
        wr(TPI_IDX_CONTROL, STP & ~DTD | RUN | ACT);
        wr(TPI_IDX_BUF_FIRST, 32'h3e);
        wait_car;
        @(posedge mclk);
        cmp(gate_level[0], 1'b0);
        @(posedge mclk);
        cmp(gate_level[0], 1'b1);
        @(posedge mclk);
        cmp(gate_level[0], 1'b0);
        nmi_n <= 1'b0;
        k = 0;
        do begin
            @(posedge mclk);
            k++;
        end while (!nmi_irq && k < 10);
        cmp(nmi_irq, 1'b1);
        repeat (8) @(posedge mclk);
        cmp(gate_oe, 6'h00);
        nmi_n <= 1'b1;
        cmp(shoot_cnt, 0);
        $display("cutoff test done");
        end_sim;
    end
endmodule
